/* File: sector_protect_lock_control.v */
// Sector protection, lock bit and protection read-back for a serial flash.
`timescale 1ns/1ps
`default_nettype none
`include "sector_protect_map.vh"

module sector_protect_lock_control (
    input wire clk_sys,
    input wire sys_rst,
    input wire spi_cs_n,
    input wire spi_sck,
    input wire spi_si,
    input wire write_protect_n,
    input wire erase_program_error,
    input wire [1:0] status_low_bits,
    output reg spi_so,
    output reg spi_so_oe,
    output reg protection_lock_bit,
    output wire [1:0] protection_summary_field,
    output wire protect_pin_state_bit,
    output wire hardware_locked,
    output wire sectors_locked,
    output reg [`NUM_SECTORS-1:0] sector_protect
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_OPCODE = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_READ = 3'h4;
    localparam [2:0] ST_IGNORE = 3'h5;

    localparam [4:0] OPCODE_LAST = 5'd7;
    localparam [4:0] ADDR_LAST = 5'd23;
    localparam [4:0] WDATA_FULL = 5'd8;
    localparam [4:0] WDATA_OVER = 5'd9;

    wire cs_n_s;
    wire sck_s;
    wire si_s;
    wire wp_n_s;

    // Chip select and write protect idle high and the serial clock idles
    // low, so the edge detector sees no false edge after reset.
    pin_sync #(
        .WIDTH(4),
        .RST_VAL(4'h9)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in({spi_cs_n, spi_sck, spi_si, write_protect_n}),
        .pin_out({cs_n_s, sck_s, si_s, wp_n_s})
    );

    reg sck_d;
    reg [2:0] state;
    reg [4:0] bit_cnt;
    reg [`ADDR_BITS-1:0] shift;
    reg read_status;
    reg [`SECT_IDX_W-1:0] read_sector;
    reg [2:0] out_idx;
    reg [7:0] out_byte;

    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire [`ADDR_BITS-1:0] shift_in = {shift[`ADDR_BITS-2:0], si_s};

    // Summary of the sector bits, recomputed every cycle.
    wire all_prot = &sector_protect;
    wire none_prot = ~|sector_protect;
    reg [1:0] summary_code;

    always @* begin
        if (all_prot) begin
            summary_code = `SUM_ALL;
        end else if (none_prot) begin
            summary_code = `SUM_NONE;
        end else begin
            summary_code = `SUM_SOME;
        end
    end

    assign protection_summary_field = summary_code;

    // Pin low means asserted, and the status bit follows the pin level.
    assign protect_pin_state_bit = wp_n_s;
    assign hardware_locked = ~wp_n_s & protection_lock_bit;
    assign sectors_locked = protection_lock_bit;

    // Status byte built from live state; written bits 5..2 are never kept.
    reg [7:0] status_byte;

    always @* begin
        status_byte = 8'h00;
        status_byte[`ST_LOCK_BIT] = protection_lock_bit;
        status_byte[`ST_RSVD_BIT] = 1'b0;
        status_byte[`ST_ERR_BIT] = erase_program_error;
        status_byte[`ST_PIN_BIT] = protect_pin_state_bit;
        status_byte[`ST_SUM_MSB:`ST_SUM_LSB] =
            protection_summary_field;
        status_byte[1:0] = status_low_bits;
    end

    // The sector read carries only the stored bit, never the pin.
    wire [7:0] sect_byte = sector_protect[read_sector] ?
        `SECT_BYTE_PROT : `SECT_BYTE_UNPROT;
    wire [7:0] next_byte = read_status ? status_byte : sect_byte;

    // A status write takes effect when chip select rises after exactly
    // one whole data byte, so an aborted write changes nothing.
    wire wr_apply = cs_n_s & (state == ST_WDATA) & (bit_cnt == WDATA_FULL);
    wire [7:0] wr_data = shift[7:0];
    wire [3:0] wr_global = wr_data[`ST_GLOBAL_MSB:`ST_GLOBAL_LSB];

    // Serial front end.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sck_d <= 1'b0;
            state <= ST_IDLE;
            bit_cnt <= 5'd0;
            shift <= {`ADDR_BITS{1'b0}};
            read_status <= 1'b0;
            read_sector <= {`SECT_IDX_W{1'b0}};
            out_idx <= 3'd7;
            out_byte <= 8'h00;
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            sck_d <= sck_s;
            if (cs_n_s) begin
                // Deselect ends any command, even mid-byte.
                state <= ST_IDLE;
                spi_so_oe <= 1'b0;
                bit_cnt <= 5'd0;
                out_idx <= 3'd7;
            end else begin
                case (state)
                    ST_IDLE: begin
                        state <= ST_OPCODE;
                        bit_cnt <= 5'd0;
                    end
                    ST_OPCODE: begin
                        if (sck_rise) begin
                            shift <= shift_in;
                            bit_cnt <= bit_cnt + 5'd1;
                            if (bit_cnt == OPCODE_LAST) begin
                                bit_cnt <= 5'd0;
                                case (shift_in[7:0])
                                    `OP_WRITE_STATUS: begin
                                        state <= ST_WDATA;
                                    end
                                    `OP_READ_STATUS: begin
                                        state <= ST_READ;
                                        read_status <= 1'b1;
                                    end
                                    `OP_READ_SECT_PROT: begin
                                        state <= ST_ADDR;
                                        read_status <= 1'b0;
                                    end
                                    default: begin
                                        state <= ST_IGNORE;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (sck_rise) begin
                            shift <= shift_in;
                            bit_cnt <= bit_cnt + 5'd1;
                            if (bit_cnt == ADDR_LAST) begin
                                // Bits below the sector boundary are ignored.
                                read_sector <= shift_in[`SECT_ADDR_MSB:
                                    `SECT_ADDR_LSB];
                                state <= ST_READ;
                                bit_cnt <= 5'd0;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (sck_rise) begin
                            shift <= shift_in;
                            // Any bit past the first byte spoils the write.
                            if (bit_cnt == WDATA_FULL) begin
                                bit_cnt <= WDATA_OVER;
                            end else if (bit_cnt != WDATA_OVER) begin
                                bit_cnt <= bit_cnt + 5'd1;
                            end
                        end
                    end
                    ST_READ: begin
                        // New data leaves on falling edges so that the host
                        // samples it on the following rising edge.
                        if (sck_fall) begin
                            spi_so_oe <= 1'b1;
                            out_idx <= out_idx - 3'd1;
                            if (out_idx == 3'd7) begin
                                out_byte <= next_byte;
                                spi_so <= next_byte[7];
                            end else begin
                                spi_so <= out_byte[out_idx];
                            end
                        end
                    end
                    ST_IGNORE: begin
                        state <= ST_IGNORE;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Lock bit and sector protection bits, worked out for the write that
    // commits in this cycle.
    reg next_lock;
    reg [`NUM_SECTORS-1:0] next_sect;

    always @* begin
        next_lock = protection_lock_bit;
        next_sect = sector_protect;
        if (wr_apply) begin
            if (hardware_locked) begin
                // The whole write is dropped; the lock bit cannot fall.
                next_lock = protection_lock_bit;
                next_sect = sector_protect;
            end else if (protection_lock_bit) begin
                // Soft lock: only the lock bit may change, and a global
                // pattern needs a second write after it is cleared.
                next_lock = wr_data[`ST_LOCK_BIT];
                next_sect = sector_protect;
            end else begin
                // An unlocked write may set the lock and run a global
                // function at once, since both are decided here together.
                next_lock = wr_data[`ST_LOCK_BIT];
                case (wr_global)
                    `GLOBAL_UNPROTECT: begin
                        next_sect = {`NUM_SECTORS{1'b0}};
                    end
                    `GLOBAL_PROTECT: begin
                        next_sect = {`NUM_SECTORS{1'b1}};
                    end
                    default: begin
                        next_sect = sector_protect;
                    end
                endcase
            end
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            // Reset clears the lock bit; raising the write protect pin also ends a hardware lock.
            protection_lock_bit <= `LOCK_RST;
            sector_protect <= `SECT_PROT_RST;
        end else begin
            protection_lock_bit <= next_lock;
            sector_protect <= next_sect;
        end
    end

endmodule // sector_protect_lock_control

`default_nettype wire

/* File: sector_protect_map.vh */
// Constants for the sector protection and lock control block.
`ifndef SECTOR_PROTECT_MAP_VH
`define SECTOR_PROTECT_MAP_VH

// Command opcodes.
`define OP_WRITE_STATUS 8'h01
`define OP_READ_STATUS 8'h05
`define OP_READ_SECT_PROT 8'h3c

// Array geometry: 64 sectors of 64 Kbyte, three address bytes.
`define NUM_SECTORS 64
`define SECT_IDX_W 6
`define SECT_ADDR_MSB 21
`define SECT_ADDR_LSB 16
`define ADDR_BITS 24

// Status byte field positions.
`define ST_LOCK_BIT 7
`define ST_RSVD_BIT 6
`define ST_ERR_BIT 5
`define ST_PIN_BIT 4
`define ST_SUM_MSB 3
`define ST_SUM_LSB 2
`define ST_GLOBAL_MSB 5
`define ST_GLOBAL_LSB 2

// Global function patterns decoded from written bits 5..2.
`define GLOBAL_UNPROTECT 4'h0
`define GLOBAL_PROTECT 4'hf

// Summary field codes.
`define SUM_NONE 2'h0
`define SUM_SOME 2'h1
`define SUM_ALL 2'h3

// Reset values.
`define LOCK_RST 1'b0
`define SECT_PROT_RST 64'hffffffffffffffff

// Read-back bytes for one sector.
`define SECT_BYTE_PROT 8'hff
`define SECT_BYTE_UNPROT 8'h00

`endif

/* File: pin_sync.v */
// Two-flip-flop synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_out
);

    reg [WIDTH-1:0] meta;

    // The first stage is read only by the second stage.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            pin_out <= RST_VAL;
        end else begin
            meta <= pin_in;
            pin_out <= meta;
        end
    end

endmodule // pin_sync

`default_nettype wire

/* File: sector_protect_lock_control_asserts.sv */
// Port-level checks for the sector protection and lock block.
`timescale 1ns/1ps
`default_nettype none
`include "sector_protect_map.vh"
module sector_protect_checks (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic write_protect_n,
    input wire logic spi_so_oe,
    input wire logic protection_lock_bit,
    input wire logic [1:0] protection_summary_field,
    input wire logic protect_pin_state_bit,
    input wire logic hardware_locked,
    input wire logic sectors_locked,
    input wire logic [`NUM_SECTORS-1:0] sector_protect
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    hw_lock_a: assert property (
        hardware_locked |=> protection_lock_bit && sectors_locked)
        else $error("Lock bit left a hard lock.");
    soft_lock_a: assert property (
        protection_lock_bit |=> $stable(sector_protect))
        else $error("Sectors changed while locked.");
    global_only_a: assert property (
        !$stable(sector_protect) |-> sector_protect == 0 || &sector_protect)
        else $error("Sectors changed to a mixed value.");
    sum_field_a: assert property (
        protection_summary_field == (&sector_protect ? 2'h3
        : (|sector_protect ? 2'h1 : 2'h0)))
        else $error("Summary field wrong.");
    hw_flag_a: assert property (
        hardware_locked == (protection_lock_bit && !protect_pin_state_bit))
        else $error("Hard lock flag wrong.");
    pin_high_a: assert property (
        write_protect_n [*4] |-> protect_pin_state_bit)
        else $error("Pin bit low with pin high.");
    pin_low_a: assert property (
        !write_protect_n [*4] |-> !protect_pin_state_bit)
        else $error("Pin bit high with pin low.");
    so_float_a: assert property (
        spi_cs_n [*5] |-> !spi_so_oe)
        else $error("Output driven after deselect.");
    lock_commit_a: assert property (
        !$stable(protection_lock_bit) |-> $past(spi_cs_n, 2))
        else $error("Lock changed inside a frame.");
    oe_start_a: assert property (
        $rose(spi_so_oe) |-> !spi_cs_n)
        else $error("Output enabled while deselected.");
    cover property (hardware_locked);
    cover property (protection_lock_bit && protect_pin_state_bit);
    cover property ($fell(spi_so_oe));
endmodule // sector_protect_checks
`default_nettype wire

/* File: spi_host_model.sv */
// Host model that shifts mode 0 frames into the block and reads back.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk_sys,
    input wire logic spi_so,
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_si,
    output logic [15:0] rx_data,
    output logic rx_done
);
    int half = 4;
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_si = 1'b0;
        rx_data = 16'h0;
        rx_done = 1'b0;
    end
    // The clock rests low between frames; data toggles when unused.
    task automatic frame(input logic [31:0] tx, input int ntx, input int nrx);
        int i;
        rx_data = 16'h0;
        @(negedge clk_sys);
        spi_cs_n = 1'b0;
        for (i = 0; i < ntx + nrx; i++) begin
            spi_si = (i < ntx) ? tx[ntx - 1 - i] : ~spi_si;
            repeat (half) @(negedge clk_sys);
            spi_sck = 1'b1;
            if (i >= ntx) rx_data = {rx_data[14:0], spi_so};
            repeat (half) @(negedge clk_sys);
            spi_sck = 1'b0;
        end
        repeat (half) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        rx_done = (nrx > 0);
        repeat (2 * half) @(negedge clk_sys);
        rx_done = 1'b0;
    endtask
endmodule // spi_host_model
`default_nettype wire

/* File: sector_protect_lock_control_tb_top.sv */
// Self-checking bench for the sector protection and lock block.
`timescale 1ns/1ps
`default_nettype none
`include "sector_protect_map.vh"
module sector_protect_lock_control_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic wp_n = 1'b1;
    logic err = 1'b0;
    logic [1:0] low = 2'h0;
    logic cs_n, sck, si, so, so_oe, lock, pin, hwl, sl, rx_done, exp_lock;
    logic [1:0] sum;
    logic [`NUM_SECTORS-1:0] sect, exp_sect;
    logic [15:0] rx;
    logic so_bus;
    logic [15:0] exp_q[$];
    int err_total = 0, total_checks = 0, cyc = 0, seed = 72;
    // Bit 8 is the pin level, bits 7..0 the status byte written.
    logic [8:0] steps[16] = '{9'h100, 9'h17f, 9'h1ff, 9'h100, 9'h1ff,
        9'h10f, 9'h180, 9'h17c, 9'h17c, 9'h144, 9'h1f0, 9'h000,
        9'h10f, 9'h000, 9'h0f0, 9'h000};
    sector_protect_lock_control uut (.clk_sys, .sys_rst, .spi_cs_n(cs_n),
        .spi_sck(sck), .spi_si(si), .write_protect_n(wp_n),
        .erase_program_error(err), .status_low_bits(low), .spi_so(so),
        .spi_so_oe(so_oe), .protection_lock_bit(lock),
        .protection_summary_field(sum), .protect_pin_state_bit(pin),
        .hardware_locked(hwl), .sectors_locked(sl), .sector_protect(sect));
    // A released output shows the inverse of its last bit, so a bit that
    // the host samples while the block is not driving is caught.
    assign so_bus = so_oe ? so : ~so;
    spi_host_model host (.clk_sys, .spi_so(so_bus), .spi_cs_n(cs_n),
        .spi_sck(sck), .spi_si(si), .rx_data(rx), .rx_done);
    initial forever #25 clk_sys = ~clk_sys;
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        total_checks++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task report_and_stop;
        $display("Checks made %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end
    always @(posedge rx_done) check(rx, exp_q.pop_front());
    task automatic wr(input logic [7:0] d);
        host.frame({16'h0, `OP_WRITE_STATUS, d}, 16, 0);
        if (!(exp_lock && !wp_n)) begin
            if (!exp_lock && d[5:2] == `GLOBAL_UNPROTECT) exp_sect = '0;
            if (!exp_lock && d[5:2] == `GLOBAL_PROTECT) exp_sect = '1;
            exp_lock = d[7];
        end
        check(sect, exp_sect);
        check(lock, exp_lock);
        check(hwl, exp_lock && !wp_n);
        check(pin, wp_n);
        check(sl, exp_lock);
    endtask
    // Status is read twice over, then one sector with a random cut length.
    task automatic rd_both;
        logic [7:0] b;
        logic [23:0] a;
        int n;
        @(negedge clk_sys);
        err = 1'($random(seed));
        low = 2'($random(seed));
        b = {exp_lock, 1'b0, err, wp_n, &exp_sect ? 2'h3
            : (|exp_sect ? 2'h1 : 2'h0), low};
        exp_q.push_back({b, b});
        host.frame({24'h0, `OP_READ_STATUS}, 8, 16);
        a = 24'($random(seed));
        a[23:22] = 2'h0;
        n = 9 + ({$random(seed)} % 8);
        b = exp_sect[a[21:16]] ? `SECT_BYTE_PROT : `SECT_BYTE_UNPROT;
        exp_q.push_back({b, b} >> (16 - n));
        host.frame({`OP_READ_SECT_PROT, a}, 32, n);
    endtask
    initial begin
        exp_lock = 1'b0;
        exp_sect = '1;
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(sect, exp_sect);
        // A nine-bit write and an unknown opcode must change nothing.
        host.frame({15'h0, `OP_WRITE_STATUS, 9'h000}, 17, 0);
        host.frame({16'h0, 8'h5a, 8'h00}, 16, 0);
        check(sect, exp_sect);
        check(lock, exp_lock);
        $display("Refused frames done");
        foreach (steps[k]) begin
            wp_n = steps[k][8];
            host.half = 4 + k % 3;
            repeat (6) @(negedge clk_sys);
            wr(steps[k][7:0]);
            rd_both();
            $display("Step %0d done", k);
        end
        sys_rst = 1'b1;
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        exp_lock = 1'b0;
        exp_sect = '1;
        repeat (4) @(negedge clk_sys);
        check(lock, exp_lock);
        rd_both();
        $display("Reset test done");
        check(exp_q.size(), 0);
        report_and_stop();
    end
endmodule // sector_protect_lock_control_tb_top
bind sector_protect_lock_control sector_protect_checks chk (.clk_sys,
    .sys_rst, .spi_cs_n, .write_protect_n, .spi_so_oe, .protection_lock_bit,
    .protection_summary_field, .protect_pin_state_bit, .hardware_locked,
    .sectors_locked, .sector_protect);
`default_nettype wire
